// ==== dv/testbench.sv ====
// Self-checking bench for the timer 3 control and capture block.
// Assumes the register map and port timing of timer3_pkg and the design.
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] CT = timer3_pkg::CTRL_ADDR;
    localparam logic [7:0] RL = timer3_pkg::RELOAD_LOW_ADDR;
    localparam logic [7:0] RH = timer3_pkg::RELOAD_HIGH_ADDR;
    localparam logic [7:0] CL = timer3_pkg::COUNT_LOW_ADDR;
    localparam logic [7:0] CH = timer3_pkg::COUNT_HIGH_ADDR;
    logic core_clk, rst, hsel, lsel, sof_event, lfo_clk, ext_osc_clk;
    logic timer_irq_enable, timer_irq_req;
    logic [7:0] sfr_rdata, v;
    timer3_pkg::sfr_req_t req;
    int miscompares, checks;

    timer3_control_capture dut (
        .core_clk(core_clk), .rst(rst), .sfr_req(req),
        .sfr_rdata(sfr_rdata), .high_byte_clock_select(hsel),
        .low_byte_clock_select(lsel), .sof_event(sof_event),
        .lfo_clk(lfo_clk), .ext_osc_clk(ext_osc_clk),
        .timer_irq_enable(timer_irq_enable), .timer_irq_req(timer_irq_req)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= {a, 1'b1, d};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= {a, 1'b0, 8'h00};
        @(posedge core_clk);
        #1 d = sfr_rdata;
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rc

    task automatic sof_pulse();
        @(posedge core_clk);
        sof_event <= 1'b1;
        @(posedge core_clk);
        sof_event <= 1'b0;
    endtask : sof_pulse

    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog, well beyond the expected run of about 660 cycles
    initial begin
        #(40 * 5000);
        miscompares++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        req = '0;
        hsel = 1'b1;
        lsel = 1'b1;
        sof_event = 1'b0;
        lfo_clk = 1'b0;
        ext_osc_clk = 1'b0;
        timer_irq_enable = 1'b1;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        rc(CT, 8'h00);
        rc(CL, 8'h00);
        rc(CH, 8'h00);
        wr(8'h90, 8'h5A);
        rc(8'h90, 8'h00);
        chk({7'h00, timer_irq_req}, 8'h00);
        $display("test reset done");
        // Split mode, run off: only the low byte counts
        wr(RL, 8'h80);
        wr(CL, 8'hF0);
        wr(CT, 8'h08);
        repeat (40) @(posedge core_clk);
        rc(CH, 8'h00);
        rd(CL, v);
        chk({7'h00, v >= 8'h80}, 8'h01);
        rc(CT, 8'h48);
        chk({7'h00, timer_irq_req}, 8'h00);
        wr(CT, 8'h68);
        @(negedge core_clk);
        chk({7'h00, timer_irq_req}, 8'h01);
        $display("test split done");
        // 16-bit wrap reloads the whole counter
        wr(CT, 8'h00);
        wr(RL, 8'h34);
        wr(RH, 8'h12);
        wr(CH, 8'hFF);
        wr(CL, 8'hF0);
        wr(CT, 8'h04);
        repeat (30) @(posedge core_clk);
        rc(CT, 8'hC4);
        chk({7'h00, timer_irq_req}, 8'h01);
        wr(CT, 8'h00);
        rc(CH, 8'h12);
        $display("test wide done");
        // Capture from either source, only while enabled
        wr(CL, 8'hCD);
        wr(CH, 8'hAB);
        sof_pulse();
        rc(RL, 8'h34);
        wr(CT, 8'h12);
        sof_pulse();
        rc(RL, 8'h34);
        @(posedge core_clk);
        lfo_clk <= 1'b1;
        repeat (6) @(posedge core_clk);
        rc(RL, 8'hCD);
        rc(RH, 8'hAB);
        rc(CT, 8'h92);
        wr(CT, 8'h10);
        wr(CL, 8'h11);
        sof_pulse();
        rc(RL, 8'h11);
        @(posedge core_clk);
        lfo_clk <= 1'b0;
        $display("test capture done");
        // Alternate timebases: external divided by 8, then system by 12
        wr(CT, 8'h00);
        wr(CL, 8'h00);
        wr(CH, 8'h00);
        lsel <= 1'b0;
        wr(CT, 8'h05);
        repeat (160) begin
            repeat (2) @(posedge core_clk);
            ext_osc_clk <= ~ext_osc_clk;
        end
        repeat (6) @(posedge core_clk);
        rc(CL, 8'h0A);
        wr(CT, 8'h04);
        repeat (120) @(posedge core_clk);
        wr(CT, 8'h00);
        rd(CL, v);
        chk({7'h00, v >= 8'h13 && v <= 8'h15}, 8'h01);
        rc(CH, 8'h00);
        $display("test timebase done");
        // Split with run on: high byte on system clock, low on divider
        wr(CH, 8'hFE);
        wr(CL, 8'h00);
        wr(CT, 8'h0C);
        repeat (10) @(posedge core_clk);
        rc(CT, 8'h8C);
        wr(CT, 8'h08);
        rc(CH, 8'hB7);
        rd(CL, v);
        chk({7'h00, v <= 8'h03}, 8'h01);
        $display("test split run done");
        report_and_stop();
    end
endmodule : testbench

// ==== rtl/timer3_control_capture.sv ====
// Timer 3: 16-bit or split 8-bit auto-reload timer with capture mode.
// Assumes the CPU port, SOF pulse, clock selects and interrupt enable come
// from core_clk logic; the external oscillator and LFO are asynchronous pins.
`timescale 1ns/1ps
module timer3_control_capture (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Special-register port
    input wire timer3_pkg::sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // Per-byte clock selects from the clock control register
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    // Capture sources and external timebase
    input wire logic sof_event,
    input wire logic lfo_clk,
    input wire logic ext_osc_clk,
    // Interrupt controller
    input wire logic timer_irq_enable,
    output logic timer_irq_req
);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    timer3_pkg::ctrl_t ctrl_q, ctrl_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] rld_q, rld_d;
    logic [7:0] rdata_q, rdata_d;
    logic [3:0] div12_q, div12_d;
    logic [2:0] div8_q, div8_d;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic lfo_s1_q, lfo_s2_q, lfo_s3_q;

    logic wr_ctrl, wr_rl, wr_rh, wr_cl, wr_ch;
    logic ext_edge, lfo_edge, div12_tick, ext_tick, alt_tick;
    logic tick_l, tick_h, cap_event, low_wrap, high_wrap;
    logic run_l, run_h;

    assign wr_ctrl = sfr_req.wr && sfr_req.addr == timer3_pkg::CTRL_ADDR;
    assign wr_rl = sfr_req.wr && sfr_req.addr == timer3_pkg::RELOAD_LOW_ADDR;
    assign wr_rh = sfr_req.wr && sfr_req.addr == timer3_pkg::RELOAD_HIGH_ADDR;
    assign wr_cl = sfr_req.wr && sfr_req.addr == timer3_pkg::COUNT_LOW_ADDR;
    assign wr_ch = sfr_req.wr && sfr_req.addr == timer3_pkg::COUNT_HIGH_ADDR;

    // Pin synchronisers; third stage only feeds edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            lfo_s1_q <= 1'b0;
            lfo_s2_q <= 1'b0;
            lfo_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_osc_clk;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            lfo_s1_q <= lfo_clk;
            lfo_s2_q <= lfo_s1_q;
            lfo_s3_q <= lfo_s2_q;
        end
    end

    assign ext_edge = ext_s2_q && !ext_s3_q;
    assign lfo_edge = lfo_s2_q && !lfo_s3_q;

    // Alternate timebase dividers
    always_comb begin
        div12_d = div12_q;
        div8_d = div8_q;
        if (div12_q == 4'(timer3_pkg::SYSCLK_DIV - 1)) begin
            div12_d = 4'h0;
        end else begin
            div12_d = div12_q + 4'h1;
        end
        if (ext_edge) begin
            div8_d = div8_q + 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div12_q <= 4'h0;
            div8_q <= 3'h0;
        end else begin
            div12_q <= div12_d;
            div8_q <= div8_d;
        end
    end

    assign div12_tick = div12_q == 4'(timer3_pkg::SYSCLK_DIV - 1);
    assign ext_tick = ext_edge && div8_q == 3'(timer3_pkg::EXT_DIV - 1);
    assign alt_tick = ctrl_q.external_clock_select ? ext_tick : div12_tick;
    // Each byte picks system clock or the shared alternate timebase
    assign tick_l = low_byte_clock_select || alt_tick;
    assign tick_h = high_byte_clock_select || alt_tick;

    // Counting enables per byte
    always_comb begin
        if (ctrl_q.split_mode_select) begin
            run_l = tick_l;
            run_h = tick_h && ctrl_q.run_control;
        end else begin
            run_l = tick_l && ctrl_q.run_control;
            run_h = run_l && cnt_q[7:0] == timer3_pkg::BYTE_MAX;
        end
    end

    assign low_wrap = run_l && cnt_q[7:0] == timer3_pkg::BYTE_MAX;
    assign high_wrap = run_h && cnt_q[15:8] == timer3_pkg::BYTE_MAX;
    // Capture source counts only while capture is enabled
    assign cap_event = ctrl_q.capture_enable &&
        (ctrl_q.capture_source_select ? lfo_edge : sof_event);

    // Counter, reload and control next state
    always_comb begin
        cnt_d = cnt_q;
        rld_d = rld_q;
        ctrl_d = ctrl_q;
        if (run_l) begin
            cnt_d[7:0] = cnt_q[7:0] + 8'h01;
        end
        if (run_h) begin
            cnt_d[15:8] = cnt_q[15:8] + 8'h01;
        end
        // Auto-reload; capture mode lets the counter wrap freely
        if (!ctrl_q.capture_enable) begin
            if (ctrl_q.split_mode_select) begin
                if (low_wrap) begin
                    cnt_d[7:0] = rld_q[7:0];
                end
                if (high_wrap) begin
                    cnt_d[15:8] = rld_q[15:8];
                end
            end else if (high_wrap) begin
                cnt_d = rld_q;
            end
        end
        if (wr_cl) begin
            cnt_d[7:0] = sfr_req.wdata;
        end
        if (wr_ch) begin
            cnt_d[15:8] = sfr_req.wdata;
        end
        if (wr_rl) begin
            rld_d[7:0] = sfr_req.wdata;
        end
        if (wr_rh) begin
            rld_d[15:8] = sfr_req.wdata;
        end
        if (cap_event) begin
            rld_d = cnt_q;
        end
        if (wr_ctrl) begin
            ctrl_d = timer3_pkg::ctrl_t'(sfr_req.wdata);
        end
        // Hardware set wins over a software clear in the same cycle
        if (high_wrap || cap_event) begin
            ctrl_d.high_overflow_flag = 1'b1;
        end
        if (low_wrap) begin
            ctrl_d.low_overflow_flag = 1'b1;
        end
    end

    // Read data, registered one cycle after the address
    always_comb begin
        unique case (sfr_req.addr)
            timer3_pkg::CTRL_ADDR: rdata_d = ctrl_q;
            timer3_pkg::RELOAD_LOW_ADDR: rdata_d = rld_q[7:0];
            timer3_pkg::RELOAD_HIGH_ADDR: rdata_d = rld_q[15:8];
            timer3_pkg::COUNT_LOW_ADDR: rdata_d = cnt_q[7:0];
            timer3_pkg::COUNT_HIGH_ADDR: rdata_d = cnt_q[15:8];
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= timer3_pkg::ctrl_t'(timer3_pkg::CTRL_RESET);
            cnt_q <= timer3_pkg::COUNT_RESET;
            rld_q <= timer3_pkg::RELOAD_RESET;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            rld_q <= rld_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign timer_irq_req = timer_irq_enable && (ctrl_q.high_overflow_flag ||
        (ctrl_q.low_byte_irq_enable && ctrl_q.low_overflow_flag));

    // Low wrap always raises its flag
    low_flag_set_a: assert property (
        low_wrap |=> ctrl_q.low_overflow_flag)
        else $error("low wrap did not set low flag");

    // High flag holds until software writes the control register
    high_flag_hold_a: assert property (
        ctrl_q.high_overflow_flag && !wr_ctrl |=> ctrl_q.high_overflow_flag)
        else $error("high flag cleared by hardware");

    high_flag_set_a: assert property (
        high_wrap |=> ctrl_q.high_overflow_flag)
        else $error("high wrap did not set high flag");

    low_irq_gate_a: assert property (
        timer_irq_enable && !ctrl_q.high_overflow_flag |->
        timer_irq_req == (ctrl_q.low_byte_irq_enable &&
        ctrl_q.low_overflow_flag))
        else $error("low byte interrupt gating wrong");

    capture_copy_a: assert property (
        cap_event && !wr_cl && !wr_ch |=>
        rld_q == $past(cnt_q) && ctrl_q.high_overflow_flag)
        else $error("capture did not latch counter");

    capture_off_a: assert property (
        !ctrl_q.capture_enable && !wr_rl && !wr_rh |=> $stable(rld_q))
        else $error("reload changed without capture");

    split_low_run_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.run_control && tick_l &&
        cnt_q[7:0] != timer3_pkg::BYTE_MAX && !wr_cl && !wr_ctrl |=>
        cnt_q[7:0] == $past(cnt_q[7:0]) + 8'h01)
        else $error("split low byte did not count");

    stopped_hold_a: assert property (
        !ctrl_q.split_mode_select && !ctrl_q.run_control &&
        !wr_cl && !wr_ch |=> $stable(cnt_q))
        else $error("stopped 16-bit timer counted");

    wrap_reload_a: assert property (
        !ctrl_q.split_mode_select && !ctrl_q.capture_enable && run_l &&
        cnt_q == timer3_pkg::WORD_MAX && !wr_cl && !wr_ch |=>
        cnt_q == $past(rld_q))
        else $error("16-bit wrap did not reload");

    div12_period_a: assert property (
        div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
        else $error("system clock divider not twelve");

    low_flag_hold_a: assert property (
        ctrl_q.low_overflow_flag && !wr_ctrl |=> ctrl_q.low_overflow_flag)
        else $error("low flag cleared by hardware");

    high_irq_a: assert property (
        timer_irq_enable && ctrl_q.high_overflow_flag |-> timer_irq_req)
        else $error("high flag did not request interrupt");

    // Split mode: run bit gates the high byte, each byte reloads alone
    split_high_stop_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.run_control && !wr_ch |=>
        $stable(cnt_q[15:8]))
        else $error("split high byte counted while stopped");

    split_high_reload_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.capture_enable && high_wrap &&
        !wr_ch |=> cnt_q[15:8] == $past(rld_q[15:8]))
        else $error("split high byte did not reload");

    split_low_reload_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.capture_enable && low_wrap &&
        !wr_cl |=> cnt_q[7:0] == $past(rld_q[7:0]))
        else $error("split low byte did not reload");

    // Capture source selection
    sof_capture_a: assert property (
        ctrl_q.capture_enable && !ctrl_q.capture_source_select && sof_event
        |=> rld_q == $past(cnt_q) && ctrl_q.high_overflow_flag)
        else $error("frame event did not capture");

    lfo_capture_a: assert property (
        ctrl_q.capture_enable && ctrl_q.capture_source_select && lfo_s2_q &&
        !lfo_s3_q |=> rld_q == $past(cnt_q))
        else $error("oscillator edge did not capture");

    sof_ignored_a: assert property (
        ctrl_q.capture_enable && ctrl_q.capture_source_select && sof_event &&
        !lfo_edge && !wr_rl && !wr_rh |=> $stable(rld_q))
        else $error("frame event captured on wrong source");

    // Alternate timebases
    ext_tick_gap_a: assert property (
        ext_tick |=> !ext_tick [*8] ##1 !ext_tick [*7])
        else $error("external tick faster than eight edges");

    ext_gate_a: assert property (
        !ctrl_q.split_mode_select && ctrl_q.external_clock_select &&
        !low_byte_clock_select && !ext_tick && !wr_cl && !wr_ch |=>
        $stable(cnt_q))
        else $error("counted without external tick");

    div12_gate_a: assert property (
        !ctrl_q.split_mode_select && !ctrl_q.external_clock_select &&
        !low_byte_clock_select && !div12_tick && !wr_cl && !wr_ch |=>
        $stable(cnt_q))
        else $error("counted without divider tick");

    split_low_alt_a: assert property (
        ctrl_q.split_mode_select && !ctrl_q.external_clock_select &&
        !low_byte_clock_select && !div12_tick && !wr_cl |=>
        $stable(cnt_q[7:0]))
        else $error("split low byte ignored its clock select");

endmodule : timer3_control_capture

// ==== rtl/timer3_pkg.sv ====
// Package for the timer 3 control and capture block: register offsets,
// reset values, divider counts, control field layout and the port carrier.
// Assumes a byte-wide special-register port on the system clock.
package timer3_pkg;

    // Register offsets on the special-register port
    localparam logic [7:0] CTRL_ADDR = 8'h91;
    localparam logic [7:0] RELOAD_LOW_ADDR = 8'h92;
    localparam logic [7:0] RELOAD_HIGH_ADDR = 8'h93;
    localparam logic [7:0] COUNT_LOW_ADDR = 8'h94;
    localparam logic [7:0] COUNT_HIGH_ADDR = 8'h95;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;

    // Divider counts of the alternate timebase
    localparam int SYSCLK_DIV = 12;
    localparam int EXT_DIV = 8;

    // Counter limits
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [15:0] WORD_MAX = 16'hFFFF;

    // Control register layout, bit 7 first
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_enable;
        logic split_mode_select;
        logic run_control;
        logic capture_source_select;
        logic external_clock_select;
    } ctrl_t;

    // Read or write request on the special-register port; wr low is a read
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } sfr_req_t;

endpackage : timer3_pkg
